// *** gdc_csc_route.sv ***
// Purpose: decide whether card status change interrupts go to PCI
// Assumes: routing inputs are synchronous to clk
// Notes: registered result
`timescale 1ns/1ns
`default_nettype none
module gdc_csc_route
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Policy and routing state
  input wire logic policy,
  input wire logic cfgBit4,
  input wire logic [3:0] routeField,
  // Result
  output logic toPci
);
  import gdc_pkg::*;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      toPci <= 1'b0;
    else if (policy)
      toPci <= (routeField == GDC_ROUTE_PCI);
    else
      toPci <= cfgBit4;
  end
endmodule // gdc_csc_route
`default_nettype wire

// *** gdc_pkg.sv ***
// Purpose: constants for the global device control register pair
// Assumes: byte-wide configuration access on the bus clock
// Notes: shared by both configuration functions
`default_nettype none
package gdc_pkg;
  localparam logic [7:0] GDC_CTRL_OFS = 8'h92;
  localparam logic [7:0] GDC_DIAG_OFS = 8'h93;
  localparam logic [7:0] GDC_CTRL_RST = 8'h66;
  localparam logic [7:0] GDC_DIAG_RST = 8'h60;
  // Writable bits, fixed bits and their fixed values
  localparam logic [7:0] GDC_CTRL_WMASK = 8'hEF;
  localparam logic [7:0] GDC_CTRL_FIXED = 8'h00;
  localparam logic [7:0] GDC_DIAG_WMASK = 8'hBF;
  localparam logic [7:0] GDC_DIAG_FIXED = 8'h40;
  localparam int GDC_BIT_PWRHOLD = 7;
  localparam int GDC_BIT_LVCAP = 6;
  localparam int GDC_BIT_DIAG5 = 5;
  localparam int GDC_BIT_VTEST = 3;
  localparam int GDC_IRQ_HI = 2;
  localparam int GDC_IRQ_LO = 1;
  localparam int GDC_BIT_TEST0 = 0;
  localparam int GDC_BIT_IDMASK = 7;
  localparam int GDC_BIT_CSCPOL = 5;
  localparam int GDC_BIT_DTOFF = 4;
  localparam int GDC_BIT_RETRY = 3;
  localparam int GDC_BIT_CBDISC = 2;
  localparam int GDC_BIT_HDISC = 1;
  localparam int GDC_BIT_VIDOFF = 0;
  localparam logic [6:0] GDC_RETRY_SHORT = 7'h10;
  localparam logic [6:0] GDC_RETRY_LONG = 7'h40;
  localparam logic [4:0] GDC_DISC_SHORT = 5'h0A;
  localparam logic [4:0] GDC_DISC_LONG = 5'h0F;
  localparam logic [3:0] GDC_ROUTE_PCI = 4'h0;
  typedef enum logic [1:0] {
    GDC_IRQ_PAR_PCI,
    GDC_IRQ_PAR_BOTH,
    GDC_IRQ_SER_IRQ,
    GDC_IRQ_SER_ALL
  } gdc_irq_mode_e;
endpackage
`default_nettype wire

// *** gdc_regs.sv ***
// Purpose: global device control and diagnostic bytes of the card bridge
// Assumes: configuration writes and reads are single-cycle byte strobes
// Notes: both functions reach the same storage; the function number is ignored
// Functional notes
// - One control byte for both functions, reset 66h
// - Power hold refuses socket power-off in D3
// - Bit 6 forces low-voltage capable indication
// - Bit 5 read/write diagnostic, resets to 1
// - Control bit 4 reads zero always
// - Bits 2:1 select interrupt signaling mode
// - Diagnostic bit 7 masks identification reads to ones
// - Diagnostic bit 6 reads one always
// - Bit 5 selects status change routing policy
// - Bit 4 disables delayed transactions
// - Bit 3 extends retry latency 16 to 64
// - Bit 2 selects cardbus discard period
// - Bit 1 selects host discard period
// - Bit 0 disables video register model
`timescale 1ns/1ns
`default_nettype none
module gdc_regs
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Configuration access
  input wire logic cfgWrite,
  input wire logic cfgRead,
  input wire logic cfgFunc,
  input wire logic [7:0] cfgAddr,
  input wire logic [7:0] cfgWdata,
  output logic [7:0] cfgRdata,
  output logic cfgHit,
  // Identification read masking
  input wire logic [15:0] vendorIdTrue,
  input wire logic [15:0] deviceIdTrue,
  output logic [15:0] vendorIdRead,
  output logic [15:0] deviceIdRead,
  // Socket power
  input wire logic inD3,
  input wire logic powerOffReq,
  output logic powerOffGrant,
  // Controls to the rest of the bridge
  output logic lowVoltageCapable,
  output logic diagBitFive,
  output gdc_pkg::gdc_irq_mode_e irqSignalingSelect,
  output logic delayedTxnOff,
  output logic [6:0] retryLatency,
  output logic [4:0] cardbusDiscardLog2,
  output logic [4:0] hostDiscardLog2,
  output logic videoModelDisable,
  // Status change routing
  input wire logic cscCfgBit4,
  input wire logic [3:0] cscRouteField,
  output logic cscToPci
);
  import gdc_pkg::*;

  // ********************************
  // Storage
  // ********************************
  logic [7:0] ctrl_r;
  logic [7:0] diag_r;
  logic ctrlWr;
  logic diagWr;

  assign ctrlWr = cfgWrite && (cfgAddr == GDC_CTRL_OFS);
  assign diagWr = cfgWrite && (cfgAddr == GDC_DIAG_OFS);

  // Function number is not decoded, so both functions share the byte
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ctrl_r <= GDC_CTRL_RST;
    else if (ctrlWr)
      ctrl_r <= (cfgWdata & GDC_CTRL_WMASK) | GDC_CTRL_FIXED;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      diag_r <= GDC_DIAG_RST;
    else if (diagWr)
      diag_r <= (cfgWdata & GDC_DIAG_WMASK) | GDC_DIAG_FIXED;
  end

  // ********************************
  // Read path
  // ********************************
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfgRdata <= 8'h00;
      cfgHit <= 1'b0;
    end
    else
    begin
      cfgHit <= cfgRead && (cfgAddr == GDC_CTRL_OFS || cfgAddr == GDC_DIAG_OFS);
      if (cfgRead && cfgAddr == GDC_CTRL_OFS)
        cfgRdata <= ctrl_r;
      else if (cfgRead && cfgAddr == GDC_DIAG_OFS)
        cfgRdata <= diag_r;
      else
        cfgRdata <= 8'h00;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      vendorIdRead <= 16'h0000;
      deviceIdRead <= 16'h0000;
    end
    else if (diag_r[GDC_BIT_IDMASK])
    begin
      vendorIdRead <= 16'hFFFF;
      deviceIdRead <= 16'hFFFF;
    end
    else
    begin
      vendorIdRead <= vendorIdTrue;
      deviceIdRead <= deviceIdTrue;
    end
  end

  // ********************************
  // Power lock
  // ********************************
  // Grant is a level; the power logic outside holds the request until served
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      powerOffGrant <= 1'b0;
    else
      powerOffGrant <= powerOffReq && !(inD3 && ctrl_r[GDC_BIT_PWRHOLD]);
  end

  // ********************************
  // Decoded controls
  // ********************************
  // Each control is re-registered so the bridge sees a clean flop output;
  // the price is one extra cycle between a write and its effect
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      lowVoltageCapable <= 1'b0;
    else
      lowVoltageCapable <= ctrl_r[GDC_BIT_LVCAP];
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      diagBitFive <= 1'b0;
    else
      diagBitFive <= ctrl_r[GDC_BIT_DIAG5];
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      irqSignalingSelect <= GDC_IRQ_PAR_PCI;
    else
      irqSignalingSelect <= gdc_irq_mode_e'(ctrl_r[GDC_IRQ_HI:GDC_IRQ_LO]);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      delayedTxnOff <= 1'b0;
    else
      delayedTxnOff <= diag_r[GDC_BIT_DTOFF];
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      retryLatency <= GDC_RETRY_SHORT;
    else
      retryLatency <= diag_r[GDC_BIT_RETRY] ? GDC_RETRY_LONG : GDC_RETRY_SHORT;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cardbusDiscardLog2 <= GDC_DISC_LONG;
    else
      cardbusDiscardLog2 <= diag_r[GDC_BIT_CBDISC] ? GDC_DISC_SHORT : GDC_DISC_LONG;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      hostDiscardLog2 <= GDC_DISC_LONG;
    else
      hostDiscardLog2 <= diag_r[GDC_BIT_HDISC] ? GDC_DISC_SHORT : GDC_DISC_LONG;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      videoModelDisable <= 1'b0;
    else
      videoModelDisable <= diag_r[GDC_BIT_VIDOFF];
  end

  gdc_csc_route u_route
  (
    .clk(clk),
    .resetn(resetn),
    .policy(diag_r[GDC_BIT_CSCPOL]),
    .cfgBit4(cscCfgBit4),
    .routeField(cscRouteField),
    .toPci(cscToPci)
  );

  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // The function number only feeds a cover; storage is shared on purpose
  logic unusedFunc;
  assign unusedFunc = cfgFunc;

  // Antecedents other than pwr_hold_a and id_mask_a carry resetn: at the release edge the flops still sit in reset,
  // while the disable condition has already let go of the attempt started there
  reset_value_a: assert property ($rose(resetn) |->
    ctrl_r == GDC_CTRL_RST && diag_r == GDC_DIAG_RST)
    else $error("register reset value wrong");
  ctrl_read_a: assert property (resetn && cfgRead && cfgAddr == GDC_CTRL_OFS |=>
    cfgRdata == $past(ctrl_r) && cfgHit)
    else $error("control byte read mismatch");
  ctrl_store_a: assert property (resetn && ctrlWr |=>
    (ctrl_r & GDC_CTRL_WMASK) == ($past(cfgWdata) & GDC_CTRL_WMASK))
    else $error("control byte write lost");
  diag_read_a: assert property (resetn && cfgRead && cfgAddr == GDC_DIAG_OFS |=>
    cfgRdata == $past(diag_r) && cfgHit)
    else $error("diagnostic byte read mismatch");
  diag_store_a: assert property (resetn && diagWr |=>
    (diag_r & GDC_DIAG_WMASK) == ($past(cfgWdata) & GDC_DIAG_WMASK))
    else $error("diagnostic byte write lost");
  pwr_hold_a: assert property (powerOffReq && inD3 && ctrl_r[GDC_BIT_PWRHOLD] |=>
    !powerOffGrant)
    else $error("power off granted while held");
  pwr_open_a: assert property (resetn && powerOffReq &&
    !(inD3 && ctrl_r[GDC_BIT_PWRHOLD]) |=> powerOffGrant)
    else $error("power off refused while free");
  lv_cap_a: assert property (resetn |=>
    lowVoltageCapable == $past(ctrl_r[GDC_BIT_LVCAP]))
    else $error("low voltage indication wrong");
  bit_five_a: assert property (resetn |=>
    diagBitFive == $past(ctrl_r[GDC_BIT_DIAG5]))
    else $error("diagnostic bit five output wrong");
  rsvd_zero_a: assert property (resetn && cfgRead && cfgAddr == GDC_CTRL_OFS |=>
    (cfgRdata & ~GDC_CTRL_WMASK) == GDC_CTRL_FIXED)
    else $error("control bit 4 not zero");
  irq_mode_a: assert property (resetn && ctrlWr |=> ##1
    irqSignalingSelect == $past(cfgWdata[GDC_IRQ_HI:GDC_IRQ_LO], 2))
    else $error("interrupt mode not following write");
  id_mask_a: assert property (diag_r[GDC_BIT_IDMASK] |=>
    vendorIdRead == 16'hFFFF && deviceIdRead == 16'hFFFF)
    else $error("identification not masked");
  id_true_a: assert property (resetn && !diag_r[GDC_BIT_IDMASK] |=>
    vendorIdRead == $past(vendorIdTrue) && deviceIdRead == $past(deviceIdTrue))
    else $error("identification not passed through");
  diag_six_a: assert property (resetn && cfgRead && cfgAddr == GDC_DIAG_OFS |=>
    (cfgRdata & ~GDC_DIAG_WMASK) == GDC_DIAG_FIXED)
    else $error("diagnostic bit 6 not one");
  fixed_keep_a: assert property (resetn && (ctrlWr || diagWr) |=>
    (ctrl_r & ~GDC_CTRL_WMASK) == GDC_CTRL_FIXED &&
    (diag_r & ~GDC_DIAG_WMASK) == GDC_DIAG_FIXED)
    else $error("fixed bit changed by write");
  csc_route_a: assert property (resetn && diag_r[GDC_BIT_CSCPOL] |=>
    cscToPci == ($past(cscRouteField) == GDC_ROUTE_PCI))
    else $error("status change route by field wrong");
  csc_cfg_a: assert property (resetn && !diag_r[GDC_BIT_CSCPOL] |=>
    cscToPci == $past(cscCfgBit4))
    else $error("status change route by config bit wrong");
  dt_off_a: assert property (resetn |=>
    delayedTxnOff == $past(diag_r[GDC_BIT_DTOFF]))
    else $error("delayed transaction disable wrong");
  retry_len_a: assert property (resetn && diagWr && cfgWdata[GDC_BIT_RETRY] |=> ##1
    retryLatency == GDC_RETRY_LONG)
    else $error("retry latency not extended");
  cb_disc_a: assert property (resetn |=>
    cardbusDiscardLog2 == ($past(diag_r[GDC_BIT_CBDISC]) ? GDC_DISC_SHORT : GDC_DISC_LONG))
    else $error("cardbus discard period wrong");
  host_disc_a: assert property (resetn |=>
    hostDiscardLog2 == ($past(diag_r[GDC_BIT_HDISC]) ? GDC_DISC_SHORT : GDC_DISC_LONG))
    else $error("host discard period wrong");
  vid_off_a: assert property (resetn |=>
    videoModelDisable == $past(diag_r[GDC_BIT_VIDOFF]))
    else $error("video model disable wrong");

  ctrl_write_c: cover property (ctrlWr);
  diag_write_c: cover property (diagWr ##1 diag_r[GDC_BIT_IDMASK]);
  pwr_refuse_c: cover property (powerOffReq && inD3 && ctrl_r[GDC_BIT_PWRHOLD]);
  func_one_c: cover property (cfgRead && cfgFunc && cfgAddr == GDC_DIAG_OFS);
  csc_policy_c: cover property (!diag_r[GDC_BIT_CSCPOL] && cscCfgBit4);
endmodule // gdc_regs
`default_nettype wire

// *** tb.sv ***
// Purpose: self-checking bench for the global device control register pair
// Assumes: byte strobes driven on the rising edge, one request at a time
// Notes: a bit-level model of both bytes predicts every read and control output
`timescale 1ns/1ns
`default_nettype none
module tb;
  import gdc_pkg::*;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic clk = 1'b0, resetn = 1'b0, cfgWrite = 1'b0, cfgRead = 1'b0, cfgFunc = 1'b0;
  logic [7:0] cfgAddr = 8'h00, cfgWdata = 8'h00;
  logic [15:0] vendorIdTrue = 16'h0000, deviceIdTrue = 16'h0000;
  logic inD3 = 1'b0, powerOffReq = 1'b0, cscCfgBit4 = 1'b0;
  logic [3:0] cscRouteField = 4'h0;
  logic [7:0] cfgRdata;
  logic [15:0] vendorIdRead, deviceIdRead;
  logic cfgHit, powerOffGrant, lowVoltageCapable, diagBitFive, delayedTxnOff;
  logic videoModelDisable, cscToPci;
  gdc_irq_mode_e irqSignalingSelect;
  logic [6:0] retryLatency;
  logic [4:0] cardbusDiscardLog2, hostDiscardLog2;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  integer seed = 93;
  logic [31:0] rv;
  // Model of the two bytes, kept with the fixed bits already applied
  logic [7:0] mCtrl = 8'h66, mDiag = 8'h60;
  always #50 clk = ~clk;
  gdc_regs uut (.clk(clk), .resetn(resetn), .cfgWrite(cfgWrite), .cfgRead(cfgRead),
    .cfgFunc(cfgFunc), .cfgAddr(cfgAddr), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata),
    .cfgHit(cfgHit), .vendorIdTrue(vendorIdTrue), .deviceIdTrue(deviceIdTrue),
    .vendorIdRead(vendorIdRead), .deviceIdRead(deviceIdRead), .inD3(inD3),
    .powerOffReq(powerOffReq), .powerOffGrant(powerOffGrant),
    .lowVoltageCapable(lowVoltageCapable), .diagBitFive(diagBitFive),
    .irqSignalingSelect(irqSignalingSelect), .delayedTxnOff(delayedTxnOff),
    .retryLatency(retryLatency), .cardbusDiscardLog2(cardbusDiscardLog2),
    .hostDiscardLog2(hostDiscardLog2), .videoModelDisable(videoModelDisable),
    .cscCfgBit4(cscCfgBit4), .cscRouteField(cscRouteField), .cscToPci(cscToPci));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic wrap_up;
    if (n_fail == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Function number is randomised because both functions must see one storage
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    cfgWrite <= 1'b1;
    cfgAddr <= a;
    cfgWdata <= v;
    cfgFunc <= 1'($random(seed));
    @(posedge clk);
    cfgWrite <= 1'b0;
    if (a == 8'h92)
      mCtrl = v & 8'hEF;
    if (a == 8'h93)
      mDiag = v | 8'h40;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    @(posedge clk);
    cfgRead <= 1'b1;
    cfgAddr <= a;
    cfgFunc <= 1'($random(seed));
    @(posedge clk);
    cfgRead <= 1'b0;
    #1;
    chk("cfgRdata", 16'(exp), 16'(cfgRdata));
    chk("cfgHit", 16'(hit), 16'(cfgHit));
  endtask
  task automatic chk_out;
    chk("lvCap", 16'(mCtrl[6]), 16'(lowVoltageCapable));
    chk("bit5", 16'(mCtrl[5]), 16'(diagBitFive));
    chk("irqSel", 16'(mCtrl[2:1]), 16'(irqSignalingSelect));
    chk("grant", 16'(powerOffReq & ~(inD3 & mCtrl[7])), 16'(powerOffGrant));
    chk("vendor", mDiag[7] ? 16'hFFFF : vendorIdTrue, vendorIdRead);
    chk("device", mDiag[7] ? 16'hFFFF : deviceIdTrue, deviceIdRead);
    chk("csc", 16'(mDiag[5] ? cscRouteField == 4'h0 : cscCfgBit4), 16'(cscToPci));
    chk("dtOff", 16'(mDiag[4]), 16'(delayedTxnOff));
    chk("retry", mDiag[3] ? 16'h0040 : 16'h0010, 16'(retryLatency));
    chk("cbDisc", mDiag[2] ? 16'h000A : 16'h000F, 16'(cardbusDiscardLog2));
    chk("hDisc", mDiag[1] ? 16'h000A : 16'h000F, 16'(hostDiscardLog2));
    chk("vidOff", 16'(mDiag[0]), 16'(videoModelDisable));
  endtask
  // Side inputs change after both writes so each output is judged on settled causes
  task automatic step(input logic [7:0] c, input logic [7:0] d);
    logic [31:0] r;
    wr(8'h92, c);
    wr(8'h93, d);
    r = $random(seed);
    @(posedge clk);
    inD3 <= r[0];
    powerOffReq <= r[1];
    cscCfgBit4 <= r[2];
    cscRouteField <= r[3] ? 4'h0 : r[7:4];
    vendorIdTrue <= r[23:8];
    deviceIdTrue <= r[31:16];
    @(posedge clk);
    #1;
    chk_out;
  endtask
  // ****************************************
  // Sequence and watchdog
  // ****************************************
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      wrap_up;
    end
  end
  initial
  begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h92, 8'h66, 1'b1);
    rd(8'h93, 8'h60, 1'b1);
    chk_out;
    rd(8'h91, 8'h00, 1'b0);
    step(8'hF6, 8'hFF);
    rd(8'h92, 8'hE6, 1'b1);
    rd(8'h93, 8'hFF, 1'b1);
    step(8'h00, 8'h00);
    rd(8'h93, 8'h40, 1'b1);
    for (int i = 0; i < 40; i++)
    begin
      rv = $random(seed);
      step({rv[7:4], 1'b0, 2'(i), 1'b0}, rv[15:8]);
      rd(8'h92, mCtrl, 1'b1);
      rd(8'h93, mDiag, 1'b1);
    end
    wr(8'h50, 8'hFF);
    rd(8'h50, 8'h00, 1'b0);
    rd(8'h92, mCtrl, 1'b1);
    @(posedge clk);
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    mCtrl = 8'h66;
    mDiag = 8'h60;
    rd(8'h92, 8'h66, 1'b1);
    rd(8'h93, 8'h60, 1'b1);
    wrap_up;
  end
endmodule // tb
`default_nettype wire
